// ---- rtl/itrb_consts.svh ----
`ifndef ITRB_CONSTS_SVH
`define ITRB_CONSTS_SVH
`define ITRB_PORT_CTR0 2'h0
`define ITRB_PORT_CTR1 2'h1
`define ITRB_PORT_CTR2 2'h2
`define ITRB_PORT_CMD 2'h3
`define ITRB_SC_MSB 7
`define ITRB_SC_LSB 6
`define ITRB_SC_READBACK 2'h3
`define ITRB_RW_MSB 5
`define ITRB_RW_LSB 4
`define ITRB_RW_LATCH 2'h0
`define ITRB_RW_LSB_ONLY 2'h1
`define ITRB_RW_MSB_ONLY 2'h2
`define ITRB_RW_BOTH 2'h3
`define ITRB_RB_COUNT_N 5
`define ITRB_RB_STATUS_N 4
`define ITRB_MODE_MSB 3
`define ITRB_MODE_LSB 1
`define ITRB_MODE0 3'h0
`define ITRB_MODE1 3'h1
`define ITRB_MODE2 3'h2
`define ITRB_ST_OUT 7
`define ITRB_ST_NULL 6
`endif

// ---- rtl/itrb_pkg.sv ----
package itrb_pkg;
  typedef struct packed {
    logic [5:0] ctl;
    logic [15:0] hold;
    logic [15:0] ce;
    logic [15:0] snap;
    logic [7:0] stat;
    logic snap_full;
    logic stat_full;
    logic snap_hi;
    logic wr_hi;
    logic null_cnt;
    logic out;
    logic armed;
    logic run;
    logic load_req;
    logic trig;
    logic clk_d;
    logic gate_d;
  } itrb_ch_t;
  typedef struct packed {
    logic [7:0] dout;
    logic dout_oe_n;
    logic [2:0] out;
  } itrb_io_t;
endpackage

// ---- rtl/itrb_timer.sv ----
// Functional notes
// - Read-back acts only on counters whose select bits 3,2,1 are one.
// - Read-back with bit5 low snapshots count of each selected counter.
// - Snapshot holds until read or reprogram; later captures ignored.
// - Read-back with bit4 low captures status, read via counter port.
// - Status bits 5:0 are last control word bits 5:0, bit 7 is output level.
// - Status bit 6 flags a count not yet moved into counting element.
// - Before transfer, captures and reads show the old counting value.
// - Count plus status capture together; repeated captures ignored until read.
// - Status read first, then one or two count bytes, then live count.
// - Port decode by select, strobes and address; others float the bus.
// - Gate rise is trigger; clock pulse is rise then fall.
// - Mode 0 output low after control word, high at zero until rewrite.
// - Mode 0 gate high counts, low halts, no effect on output.
// - Mode 0 load on next pulse without decrement; output rises N+1 later.
// - Mode 0 first byte halts and drops output; second byte loads.
// - Mode 0 count written with gate low still loads on next pulse.
// - Mode 1 output drops on pulse after trigger, high at zero.
// - Mode 1 each trigger reloads count, output low for N pulses.
// - Mode 1 count written mid-pulse used only at next trigger.
// - Mode 2 output low one pulse at count one, then reloads.
// - Mode 2 gate low halts and forces output high; trigger reloads.
// - Mode 2 first count loads next pulse; later counts at trigger or wrap.
// - Control words and read-back only at the command port address.
// - Loads and decrements only on falling edge of counter clock.
// - Gate level used at clock fall; edge flag catches short triggers.
// - Control word write resets counter logic and output at once.
`timescale 1ns/1ps
`default_nettype none
`include "itrb_consts.svh"
module itrb_timer
  import itrb_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_sel_hi,
  input wire logic port_sel_lo,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic dout_oe_n,
  input wire logic [CHANNELS-1:0] ctr_clk,
  input wire logic [CHANNELS-1:0] ctr_gate,
  output logic [CHANNELS-1:0] ctr_out
);
  typedef struct packed {
    itrb_ch_t [CHANNELS-1:0] ch;
    logic rd_d;
    logic wr_d;
    logic [7:0] dout;
    logic dout_oe_n;
  } itrb_state_t;

  itrb_state_t st;
  itrb_state_t next_st;

  logic [1:0] addr;
  logic rd_act;
  logic wr_act;
  logic rd_stb;
  logic wr_stb;

  assign addr = {port_sel_hi, port_sel_lo};
  // Strobes are level signals; act once on the leading edge of each access
  assign rd_act = !cs_n && !rd_n && wr_n;
  assign wr_act = !cs_n && !wr_n && rd_n;
  assign rd_stb = rd_act && !st.rd_d;
  assign wr_stb = wr_act && !st.wr_d;

  assign dout = st.dout;
  assign dout_oe_n = st.dout_oe_n;
  generate
    for (genvar g = 0; g < CHANNELS; g++) begin : g_out
      assign ctr_out[g] = st.ch[g].out;
    end
  endgenerate

  always_comb begin
    itrb_ch_t c;
    logic [2:0] mode;
    logic [1:0] rw;
    logic rise;
    logic fall;
    logic [15:0] live;
    logic sel;
    logic [15:0] nxt;
    logic two;
    c = '0;
    mode = '0;
    rw = '0;
    rise = 1'b0;
    fall = 1'b0;
    live = '0;
    sel = 1'b0;
    nxt = '0;
    two = 1'b0;
    next_st = st;
    next_st.rd_d = rd_act;
    next_st.wr_d = wr_act;
    next_st.dout_oe_n = !(rd_act && addr != `ITRB_PORT_CMD);
    for (int i = 0; i < CHANNELS; i++) begin
      c = st.ch[i];
      mode = c.ctl[`ITRB_MODE_MSB:`ITRB_MODE_LSB];
      rw = c.ctl[`ITRB_RW_MSB:`ITRB_RW_LSB];
      two = (rw == `ITRB_RW_BOTH);
      rise = ctr_clk[i] && !c.clk_d;
      fall = !ctr_clk[i] && c.clk_d;
      c.clk_d = ctr_clk[i];
      c.gate_d = ctr_gate[i];
      if (ctr_gate[i] && !st.ch[i].gate_d) begin
        c.trig = 1'b1;
      end
      live = c.ce;
      if (fall) begin
        if (mode == `ITRB_MODE0) begin
          if (c.load_req) begin
            c.ce = c.hold;
            c.load_req = 1'b0;
            c.null_cnt = 1'b0;
            c.run = 1'b1;
          end else if (c.run && ctr_gate[i]) begin
            nxt = c.ce - 16'h1;
            c.ce = nxt;
            if (nxt == 16'h0) begin
              c.out = 1'b1;
            end
          end
        end else if (mode == `ITRB_MODE1) begin
          if (c.trig && c.armed) begin
            c.ce = c.hold;
            c.null_cnt = 1'b0;
            c.out = 1'b0;
            c.run = 1'b1;
          end else if (c.run) begin
            nxt = c.ce - 16'h1;
            c.ce = nxt;
            if (nxt == 16'h0) begin
              c.out = 1'b1;
              c.run = 1'b0;
            end
          end
          c.trig = 1'b0;
        end else if (mode == `ITRB_MODE2) begin
          if (c.armed && (c.load_req || c.trig || (c.run && c.ce == 16'h1))) begin
            c.ce = c.hold;
            c.null_cnt = 1'b0;
            c.load_req = 1'b0;
            c.out = 1'b1;
            c.run = 1'b1;
          end else if (c.run && ctr_gate[i]) begin
            nxt = c.ce - 16'h1;
            c.ce = nxt;
            c.out = (nxt != 16'h1);
          end
          c.trig = 1'b0;
        end
      end else if (rise) begin
        // Edge flag cleared only by a mode 1 or 2 fall or a control word, so a short gate pulse survives
        c.trig = c.trig;
      end
      if (mode == `ITRB_MODE2 && !ctr_gate[i]) begin
        c.out = 1'b1;
      end
      // Bus writes to this counter's data port
      if (wr_stb && addr == 2'(i)) begin
        if (rw == `ITRB_RW_MSB_ONLY || (two && c.wr_hi)) begin
          c.hold[15:8] = din;
          if (rw == `ITRB_RW_MSB_ONLY) begin
            c.hold[7:0] = 8'h0;
          end
        end else begin
          c.hold[7:0] = din;
          if (rw == `ITRB_RW_LSB_ONLY) begin
            c.hold[15:8] = 8'h0;
          end
        end
        if (two && !c.wr_hi) begin
          c.wr_hi = 1'b1;
          if (mode == `ITRB_MODE0) begin
            c.run = 1'b0;
            c.out = 1'b0;
          end
        end else begin
          c.wr_hi = 1'b0;
          c.null_cnt = 1'b1;
          c.armed = 1'b1;
          if (mode == `ITRB_MODE0) begin
            c.load_req = 1'b1;
            c.out = 1'b0;
          end else if (mode == `ITRB_MODE2 && !c.run) begin
            c.load_req = 1'b1;
          end
        end
      end
      // Command port
      if (wr_stb && addr == `ITRB_PORT_CMD) begin
        if (din[`ITRB_SC_MSB:`ITRB_SC_LSB] == `ITRB_SC_READBACK) begin
          sel = din[i+1];
          if (sel && !din[`ITRB_RB_COUNT_N] && !c.snap_full) begin
            c.snap = live;
            c.snap_full = 1'b1;
            c.snap_hi = (rw == `ITRB_RW_MSB_ONLY);
          end
          if (sel && !din[`ITRB_RB_STATUS_N] && !c.stat_full) begin
            c.stat = {st.ch[i].out, st.ch[i].null_cnt, c.ctl};
            c.stat_full = 1'b1;
          end
        end else if (din[`ITRB_SC_MSB:`ITRB_SC_LSB] == 2'(i)) begin
          if (din[`ITRB_RW_MSB:`ITRB_RW_LSB] == `ITRB_RW_LATCH) begin
            if (!c.snap_full) begin
              c.snap = live;
              c.snap_full = 1'b1;
              c.snap_hi = (rw == `ITRB_RW_MSB_ONLY);
            end
          end else begin
            c.ctl = din[5:0];
            c.snap_full = 1'b0;
            c.stat_full = 1'b0;
            c.snap_hi = (din[`ITRB_RW_MSB:`ITRB_RW_LSB] == `ITRB_RW_MSB_ONLY);
            c.wr_hi = 1'b0;
            c.null_cnt = 1'b1;
            c.armed = 1'b0;
            c.run = 1'b0;
            c.load_req = 1'b0;
            c.trig = 1'b0;
            c.out = (din[`ITRB_MODE_MSB:`ITRB_MODE_LSB] != `ITRB_MODE0);
          end
        end
      end
      // Reads: status first, then snapshot bytes, then live count
      if (rd_stb && addr == 2'(i)) begin
        if (c.stat_full) begin
          next_st.dout = c.stat;
          c.stat_full = 1'b0;
        end else begin
          nxt = c.snap_full ? c.snap : live;
          next_st.dout = c.snap_hi ? nxt[15:8] : nxt[7:0];
          if (two && !c.snap_hi) begin
            c.snap_hi = 1'b1;
          end else begin
            c.snap_hi = (rw == `ITRB_RW_MSB_ONLY);
            c.snap_full = 1'b0;
          end
        end
      end
      next_st.ch[i] = c;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
      st.dout_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ---- sim/interval_timer_readback_modes_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module interval_timer_readback_modes_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cs_n, rd_n, wr_n, port_sel_hi, port_sel_lo, dout_oe_n;
  logic [7:0] din, dout, d;
  logic [2:0] ctr_clk = 3'h0;
  logic [2:0] ctr_gate = 3'h0;
  logic [2:0] ctr_out;
  int errors = 0;
  int comparisons = 0;
  itrb_timer uut (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out));
  itrb_host u_host (.ref_clk(ref_clk), .dout(dout), .dout_oe_n(dout_oe_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .din(din));
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    logic oe;
    u_host.rd(a, d, oe);
    check("read data", d, exp);
    check("dout_oe_n", {7'h0, oe}, {7'h0, a == 2'h3});
  endtask
  task automatic ochk(input int ch, input logic exp);
    #1 check("ctr_out", {7'h0, ctr_out[ch]}, {7'h0, exp});
  endtask
  // Slow pulses: the counter clock is sampled by ref_clk
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge ref_clk) ctr_clk[ch] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ctr_clk[ch] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
  task automatic t_mode0;
    ctr_gate[0] <= 1'b1;
    u_host.wr(2'h3, 8'h30);
    ochk(0, 1'b0);
    u_host.wr(2'h0, 8'h03);
    u_host.wr(2'h0, 8'h00);
    u_host.wr(2'h3, 8'hE2);
    rchk(2'h0, 8'h70);
    pulse(0, 1);
    u_host.wr(2'h3, 8'hC2);
    pulse(0, 1);
    u_host.wr(2'h3, 8'hC2);
    rchk(2'h0, 8'h30);
    rchk(2'h0, 8'h03);
    rchk(2'h0, 8'h00);
    rchk(2'h0, 8'h02);
    rchk(2'h0, 8'h00);
    rchk(2'h3, 8'h00);
    pulse(0, 1);
    ochk(0, 1'b0);
    pulse(0, 1);
    ochk(0, 1'b1);
    u_host.wr(2'h0, 8'h05);
    ochk(0, 1'b0);
    u_host.wr(2'h0, 8'h00);
    u_host.wr(2'h3, 8'hD2);
    rchk(2'h0, 8'h00);
    rchk(2'h0, 8'h00);
  endtask
  task automatic t_mode2;
    ctr_gate[1] <= 1'b1;
    u_host.wr(2'h3, 8'h54);
    ochk(1, 1'b1);
    u_host.wr(2'h1, 8'h03);
    pulse(1, 2);
    ochk(1, 1'b1);
    pulse(1, 1);
    ochk(1, 1'b0);
    pulse(1, 1);
    ochk(1, 1'b1);
    pulse(1, 2);
    @(posedge ref_clk) ctr_gate[1] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ochk(1, 1'b1);
    @(posedge ref_clk) ctr_gate[1] <= 1'b1;
    pulse(1, 2);
    ochk(1, 1'b1);
    pulse(1, 1);
    ochk(1, 1'b0);
  endtask
  task automatic t_mode1;
    u_host.wr(2'h3, 8'h92);
    ochk(2, 1'b1);
    u_host.wr(2'h2, 8'h02);
    pulse(2, 2);
    ochk(2, 1'b1);
    @(posedge ref_clk) ctr_gate[2] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ctr_gate[2] <= 1'b0;
    pulse(2, 1);
    ochk(2, 1'b0);
    pulse(2, 1);
    ochk(2, 1'b0);
    pulse(2, 1);
    ochk(2, 1'b1);
  endtask
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    t_mode0;
    t_mode2;
    t_mode1;
    test_done;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge ref_clk);
    errors++;
    test_done;
  end
endmodule
`default_nettype wire

// ---- sim/itrb_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module itrb_assertions #(
  parameter int CHANNELS = 3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_sel_hi,
  input wire logic port_sel_lo,
  input wire logic [7:0] din,
  input wire logic [7:0] dout,
  input wire logic dout_oe_n,
  input wire logic [CHANNELS-1:0] ctr_clk,
  input wire logic [CHANNELS-1:0] ctr_gate,
  input wire logic [CHANNELS-1:0] ctr_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire cmd = port_sel_hi & port_sel_lo;
  wire wr = !cs_n && !wr_n && rd_n && cmd;
  wire rd_ok = !cs_n && !rd_n && wr_n && !cmd;
  wire [1:0] sel = din[7:6];
  wire m0 = din[3:1] == 3'h0;
  // Modes 3 to 7 left out: their outputs are held
  wire ctl = wr && sel != 2'h3 && din[5:4] != 2'h0 && din[3:1] < 3'h3;
  property p_on; rd_ok [*3] |-> !dout_oe_n; endproperty
  a_on: assert property (p_on) else $error("no drive on read");
  property p_cmd; (!cs_n && !rd_n && wr_n && cmd) [*2] |-> dout_oe_n; endproperty
  a_cmd: assert property (p_cmd) else $error("drive at command port");
  property p_idle; rd_n [*2] |-> dout_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("drive without read");
  property p_cs; cs_n [*2] |-> dout_oe_n; endproperty
  a_cs: assert property (p_cs) else $error("drive while deselected");
  property p_fell; $fell(dout_oe_n) |-> $past(rd_ok) || $past(rd_ok, 2); endproperty
  a_fell: assert property (p_fell) else $error("drive with no cause");
  property p_hold; !$stable(dout) |-> !$past(rd_n) || !$past(rd_n, 2); endproperty
  a_hold: assert property (p_hold) else $error("read data moved alone");
  property p_ctl; ctl |-> ##2 ctr_out[$past(sel, 2)] != $past(m0, 2); endproperty
  a_ctl: assert property (p_ctl) else $error("wrong initial output");
  property p_rb; (wr && sel == 2'h3) |=> $stable(ctr_out) [*2]; endproperty
  a_rb: assert property (p_rb) else $error("read-back moved output");
  c_read: cover property ($fell(dout_oe_n));
  c_rise: cover property ($rose(ctr_out[0]));
  c_rb: cover property (wr && sel == 2'h3);
endmodule
bind itrb_timer itrb_assertions #(.CHANNELS(CHANNELS)) u_chk (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .din(din), .dout(dout),
  .dout_oe_n(dout_oe_n), .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out));
`default_nettype wire

// ---- sim/itrb_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module itrb_host (
  input wire logic ref_clk,
  input wire logic [7:0] dout,
  input wire logic dout_oe_n,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic port_sel_hi,
  output logic port_sel_lo,
  output logic [7:0] din
);
  initial {cs_n, rd_n, wr_n, port_sel_hi, port_sel_lo, din} = {3'h7, 2'h0, 8'h00};
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {port_sel_hi, port_sel_lo, din, cs_n, wr_n} <= {a, d, 2'h0};
    @(posedge ref_clk);
    {din, cs_n, wr_n} <= {~d, 2'h3}; // Released bus shows no stale data
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic oe);
    @(posedge ref_clk);
    {port_sel_hi, port_sel_lo, cs_n, rd_n} <= {a, 2'h0};
    repeat (3) @(posedge ref_clk);
    d = dout;
    oe = dout_oe_n;
    {cs_n, rd_n} <= 2'h3;
    @(posedge ref_clk); // Strobe high between accesses
  endtask
endmodule
`default_nettype wire
